// file: hw/cbu_branch_unit.sv
// compact branch resolution: condition, pc-relative target, link write, exceptions
// assumes decode presents one request per cycle with operands already read,
// and coprocessor 2 answers cond_selector with a condition in the same cycle
`timescale 1ns/10ps
`include "cbu_params.svh"

module cbu_branch_unit (
    input  wire logic              clock_i,
    input  wire logic              sys_rst_i,
    input  wire cbu_pkg::cbu_req_t req_i,
    input  wire logic              cop2_enable_i,
    input  wire logic              cop2_cond_i,
    output logic [4:0]             cop2_sel_o,
    output cbu_pkg::cbu_res_t      res_o
);

    // ------------------------------------------------------------------
    // operand views
    // ------------------------------------------------------------------
    logic [31:0] next_pc;
    logic [31:0] off17;
    logic [31:0] off18;
    logic [31:0] off23;
    logic        a_zero;
    logic        b_zero;
    logic        b_neg;
    logic        regs_eq;
    logic        s_less;
    logic        u_less;

    // address after the branch is the base of every target
    assign next_pc = req_i.pc + `CBU_INSN_BYTES;                        // RULE3
    assign off17   = {{15{req_i.offset[15]}}, req_i.offset[15:0], 1'b0}; // RULE3
    assign off18   = {{14{req_i.offset[15]}}, req_i.offset[15:0], 2'b00}; // RULE11
    assign off23   = {{9{req_i.offset[20]}}, req_i.offset[20:0], 2'b00}; // RULE12

    // comparisons shared by the families
    assign a_zero  = (req_i.src_a == 32'h0000_0000);                    // RULE21
    assign b_zero  = (req_i.src_b == 32'h0000_0000);
    assign b_neg   = req_i.src_b[31];                                   // RULE10
    assign regs_eq = (req_i.src_a == req_i.src_b);                      // RULE13
    assign s_less  = ($signed(req_i.src_a) < $signed(req_i.src_b));     // RULE14
    assign u_less  = (req_i.src_a < req_i.src_b);                       // RULE15

    // ------------------------------------------------------------------
    // per-operation decode
    // ------------------------------------------------------------------
    logic        is_c2;
    logic        is_link;
    logic        is_long;
    logic        known_op;
    logic        cond;
    logic [31:0] offset_ext;

    assign is_c2    = (req_i.op == `CBU_OP_C2_EQZ) || (req_i.op == `CBU_OP_C2_NEZ);
    assign is_link  = (req_i.op >= `CBU_OP_L_LEZ) && (req_i.op <= `CBU_OP_L_NEZ);
    assign is_long  = (req_i.op == `CBU_OP_Z_EQZ) || (req_i.op == `CBU_OP_Z_NEZ); // RULE12
    assign known_op = (req_i.op != `CBU_OP_NONE) && (req_i.op <= `CBU_OP_LAST);

    // short offset for cop2/link, long for the two wide zero compares
    assign offset_ext = (is_c2 || is_link) ? off17 :                    // RULE3
                        (is_long ? off23 : off18);                      // RULE11 RULE17

    // condition per operation; swapped-operand idioms need no logic here
    always_comb begin
        unique case (req_i.op)
            `CBU_OP_C2_EQZ: cond = ~cop2_cond_i;                        // RULE2 RULE22
            `CBU_OP_C2_NEZ: cond = cop2_cond_i;                         // RULE2
            `CBU_OP_L_LEZ:  cond = b_neg | b_zero;                      // RULE10
            `CBU_OP_L_GEZ:  cond = ~b_neg;                              // RULE10
            `CBU_OP_L_GTZ:  cond = ~b_neg & ~b_zero;                    // RULE10
            `CBU_OP_L_LTZ:  cond = b_neg;                               // RULE10
            `CBU_OP_L_EQZ:  cond = b_zero;                              // RULE10
            `CBU_OP_L_NEZ:  cond = ~b_zero;                             // RULE10
            `CBU_OP_R_EQ:   cond = regs_eq;                             // RULE13
            `CBU_OP_R_NE:   cond = ~regs_eq;                            // RULE13
            `CBU_OP_R_LT:   cond = s_less;                              // RULE14 RULE16
            `CBU_OP_R_GE:   cond = ~s_less;                             // RULE14 RULE16
            `CBU_OP_R_LTU:  cond = u_less;                              // RULE15 RULE16
            `CBU_OP_R_GEU:  cond = ~u_less;                             // RULE20 RULE16
            `CBU_OP_Z_LTZ:  cond = b_neg;                               // RULE17
            `CBU_OP_Z_LEZ:  cond = b_neg | b_zero;                      // RULE17
            `CBU_OP_Z_GEZ:  cond = ~b_neg;                              // RULE17
            `CBU_OP_Z_GTZ:  cond = ~b_neg & ~b_zero;                    // RULE17
            `CBU_OP_Z_EQZ:  cond = a_zero;                              // RULE21
            `CBU_OP_Z_NEZ:  cond = ~a_zero;                             // RULE21
            default:        cond = 1'b0;                                // unknown op code
        endcase
    end

    // ------------------------------------------------------------------
    // result assembly
    // ------------------------------------------------------------------
    logic   c2_unusable;
    logic   reserved;
    logic   taken;
    cbu_pkg::cbu_res_t res_next;

    // a faulting cop2 branch must neither redirect nor squash
    assign c2_unusable = req_i.valid && is_c2 && !cop2_enable_i;        // RULE6 RULE7
    assign reserved    = req_i.valid && !known_op;                      // RULE7
    assign taken       = req_i.valid && known_op && !c2_unusable && cond; // RULE18

    always_comb begin
        res_next                  = '0;
        res_next.valid            = req_i.valid;
        res_next.taken            = taken;                              // RULE18
        res_next.target           = taken ? (next_pc + offset_ext) : next_pc; // RULE18
        res_next.squash_next      = taken;                              // RULE4
        res_next.link_we          = req_i.valid && is_link;             // RULE8 RULE9
        res_next.link_reg         = `CBU_LINK_REG;                      // RULE8
        res_next.link_data        = next_pc;                            // RULE8
        res_next.exc_cop_unusable = c2_unusable;                        // RULE6
        res_next.exc_reserved     = reserved;                           // RULE7
    end

    // ------------------------------------------------------------------
    // output registers; one result per cycle, no hazard interlock
    // since any instruction may follow a branch directly
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            res_o <= '0;
        end else begin
            res_o <= res_next;                                          // RULE5
        end
    end

    // selector registered too; it mirrors the request selector by one cycle
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cop2_sel_o <= 5'h00;
        end else begin
            cop2_sel_o <= req_i.cond_selector;                          // RULE1 RULE19
        end
    end

endmodule : cbu_branch_unit

// file: hw/cbu_params.svh
// constants for the compact branch unit: operation codes, field widths, link register
// assumes inclusion by cbu_pkg and the design file
// Operation
// [RULE1] the five-bit condition selector picks which coprocessor-2 condition is tested
// [RULE2] zero variant takes on condition zero, nonzero variant on condition nonzero
// [RULE3] cop2 and link branches: offset shifted one, sign-extended to 17 bits, plus next pc
// [RULE4] a taken compact branch suppresses the following instruction; no delay slot
// [RULE5] any instruction, even a branch, may directly follow a compact branch
// [RULE6] cop2 branch with coprocessor 2 disabled raises coprocessor unusable
// [RULE7] cop2 branches raise only coprocessor unusable or reserved instruction
// [RULE8] link branches write the next instruction address into register 31
// [RULE9] the link write happens whether or not the branch is taken
// [RULE10] six link branches test source_b signed: le, ge, lt, gt, eq, ne zero
// [RULE11] compare family: offset shifted two, sign-extended to 18 or 23 bits, plus next pc
// [RULE12] long zero compares use a 21-bit offset; the others use 16 bits
// [RULE13] register equality takes when equal, inequality takes when values differ
// [RULE14] signed register branches take on less-than or greater-or-equal, two's complement
// [RULE15] unsigned less-than takes when source_a is below source_b
// [RULE16] greater and not-greater idioms are issued with the operands swapped
// [RULE17] signed register-versus-zero branches use a 16-bit offset
// [RULE18] redirect the pc to the target only when the condition holds
// [RULE19] coprocessor may use all selector bits freely, e.g. 32 flags
// [RULE20] unsigned not-less takes when source_a is not below source_b
// [RULE21] long zero compares test source_a against zero
// [RULE22] coprocessor presents the selected condition in the resolving cycle; cop2_sel_o here follows the request selector one cycle later
`ifndef CBU_PARAMS_SVH
`define CBU_PARAMS_SVH

// ----------------------------------------------------------------------
// operation codes presented by the decoder
// ----------------------------------------------------------------------
`define CBU_OP_NONE      5'h00
`define CBU_OP_C2_EQZ    5'h01
`define CBU_OP_C2_NEZ    5'h02
`define CBU_OP_L_LEZ     5'h03
`define CBU_OP_L_GEZ     5'h04
`define CBU_OP_L_GTZ     5'h05
`define CBU_OP_L_LTZ     5'h06
`define CBU_OP_L_EQZ     5'h07
`define CBU_OP_L_NEZ     5'h08
`define CBU_OP_R_EQ      5'h09
`define CBU_OP_R_NE      5'h0A
`define CBU_OP_R_LT      5'h0B
`define CBU_OP_R_GE      5'h0C
`define CBU_OP_R_LTU     5'h0D
`define CBU_OP_R_GEU     5'h0E
`define CBU_OP_Z_LTZ     5'h0F
`define CBU_OP_Z_LEZ     5'h10
`define CBU_OP_Z_GEZ     5'h11
`define CBU_OP_Z_GTZ     5'h12
`define CBU_OP_Z_EQZ     5'h13
`define CBU_OP_Z_NEZ     5'h14
`define CBU_OP_LAST      5'h14

// ----------------------------------------------------------------------
// field widths and fixed values
// ----------------------------------------------------------------------
`define CBU_OFF_SHORT_W  16
`define CBU_OFF_LONG_W   21
`define CBU_SEL_W        5
`define CBU_LINK_REG     5'h1F
`define CBU_INSN_BYTES   32'h0000_0004

`endif

// file: hw/cbu_pkg.sv
// types of the compact branch unit: request and result bundles
// assumes cbu_params.svh on the include path
`include "cbu_params.svh"

package cbu_pkg;

    // ------------------------------------------------------------------
    // request from decode and result to fetch / writeback
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [4:0]  op;
        logic [31:0] pc;
        logic [31:0] src_a;
        logic [31:0] src_b;
        logic [20:0] offset;
        logic [4:0]  cond_selector;
    } cbu_req_t;

    typedef struct packed {
        logic        valid;
        logic        taken;
        logic [31:0] target;
        logic        squash_next;
        logic        link_we;
        logic [4:0]  link_reg;
        logic [31:0] link_data;
        logic        exc_cop_unusable;
        logic        exc_reserved;
    } cbu_res_t;

endpackage : cbu_pkg

// file: testbench/cbu_branch_props.sv
// checker for the compact branch unit, watching its ports only
// assumes cbu_params.svh on the include path; bound below to cbu_branch_unit
`timescale 1ns/10ps
`include "cbu_params.svh"
module cbu_branch_props (
    input wire logic              clock_i,
    input wire logic              sys_rst_i,
    input wire cbu_pkg::cbu_req_t req_i,
    input wire logic              cop2_enable_i,
    input wire logic              cop2_cond_i,
    input wire logic [4:0]        cop2_sel_o,
    input wire cbu_pkg::cbu_res_t res_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // link codes form one contiguous range, so a range test is enough
    wire is_link = req_i.valid && req_i.op >= `CBU_OP_L_LEZ && req_i.op <= `CBU_OP_L_NEZ;
    wire is_cop2 = req_i.valid && (req_i.op == `CBU_OP_C2_EQZ || req_i.op == `CBU_OP_C2_NEZ);
    sequence s_issue; req_i.valid; endsequence
    sequence s_link; res_o.link_we && res_o.link_reg == `CBU_LINK_REG; endsequence
    answer_once_a: assert property (s_issue |=> res_o.valid)
        else $error("request gave no result");
    idle_quiet_a: assert property (!req_i.valid |=> !res_o.valid && !res_o.taken)
        else $error("result without request");
    link_write_a: assert property (is_link |=> s_link ##0
        res_o.link_data == $past(req_i.pc) + 32'h4) else $error("link write wrong");
    squash_taken_a: assert property (res_o.valid |-> res_o.squash_next == res_o.taken)
        else $error("squash differs from taken");
    cop_unusable_a: assert property (is_cop2 && !cop2_enable_i |=>
        res_o.exc_cop_unusable && !res_o.taken) else $error("disabled cop2 branch");
    cop2_cond_a: assert property (is_cop2 && cop2_enable_i |=> !res_o.exc_cop_unusable &&
        res_o.taken == ($past(cop2_cond_i) ^ ($past(req_i.op) == `CBU_OP_C2_EQZ)))
        else $error("cop2 condition wrong");
    fall_through_a: assert property (s_issue ##1 !res_o.taken |->
        res_o.target == $past(req_i.pc) + 32'h4) else $error("not-taken target wrong");
    reg_equal_a: assert property (req_i.valid && req_i.op == `CBU_OP_R_EQ |=>
        res_o.taken == ($past(req_i.src_a) == $past(req_i.src_b))) else $error("equality");
    select_copy_a: assert property (s_issue |=> cop2_sel_o == $past(req_i.cond_selector))
        else $error("selector copy wrong");
    reserved_op_a: assert property (req_i.valid && req_i.op > `CBU_OP_LAST |=>
        res_o.exc_reserved && !res_o.taken) else $error("unknown code not refused");
endmodule : cbu_branch_props

bind cbu_branch_unit cbu_branch_props props (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .req_i(req_i), .cop2_enable_i(cop2_enable_i), .cop2_cond_i(cop2_cond_i),
    .cop2_sel_o(cop2_sel_o), .res_o(res_o));

// file: testbench/cbu_branch_unit_tb.sv
// self-checking bench for the compact branch unit
// assumes the package, the cop2 model and the checker are compiled first
`timescale 1ns/10ps
`include "cbu_params.svh"
module cbu_branch_unit_tb;
    logic              clock_i = 1'b0;
    logic              sys_rst_i = 1'b1;
    cbu_pkg::cbu_req_t req_i = '0;
    logic              cop2_enable_i = 1'b1;
    logic [31:0]       flags = 32'hA5C3_0F01;
    logic              cop2_cond_i;
    logic [4:0]        cop2_sel_o;
    cbu_pkg::cbu_res_t res_o;
    int                fails = 0;
    int                checks_done = 0;
    int                cycles = 0;
    logic [31:0]       pc = 32'h0000_1000;
    always #5 clock_i = ~clock_i;
    cbu_cop2_model cop2 (.sel_i(req_i.cond_selector), .flags_i(flags), .cond_o(cop2_cond_i));
    cbu_branch_unit dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
        .cop2_enable_i(cop2_enable_i), .cop2_cond_i(cop2_cond_i), .cop2_sel_o(cop2_sel_o),
        .res_o(res_o));
    // ----------------------------------------------------------------
    // reference condition, comparison and request driver
    // ----------------------------------------------------------------
    function automatic logic cond_of(input logic [4:0] op, input logic [31:0] a,
                                     input logic [31:0] b, input logic c);
        case (op)
            `CBU_OP_C2_EQZ: return !c;
            `CBU_OP_C2_NEZ: return c;
            `CBU_OP_L_LEZ, `CBU_OP_Z_LEZ: return $signed(b) <= 0;
            `CBU_OP_L_GEZ, `CBU_OP_Z_GEZ: return $signed(b) >= 0;
            `CBU_OP_L_GTZ, `CBU_OP_Z_GTZ: return $signed(b) > 0;
            `CBU_OP_L_LTZ, `CBU_OP_Z_LTZ: return $signed(b) < 0;
            `CBU_OP_L_EQZ: return b == 32'h0;
            `CBU_OP_L_NEZ: return b != 32'h0;
            `CBU_OP_R_EQ: return a == b;
            `CBU_OP_R_NE: return a != b;
            `CBU_OP_R_LT: return $signed(a) < $signed(b);
            `CBU_OP_R_GE: return $signed(a) >= $signed(b);
            `CBU_OP_R_LTU: return a < b;
            `CBU_OP_R_GEU: return a >= b;
            `CBU_OP_Z_EQZ: return a == 32'h0;
            `CBU_OP_Z_NEZ: return a != 32'h0;
            default: return 1'b0;
        endcase
    endfunction : cond_of
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : check
    // one request per call; calls run back to back with no idle cycle between
    task automatic issue(input logic [4:0] op, input logic [31:0] a, input logic [31:0] b,
                         input logic [20:0] off, input logic [4:0] sel);
        logic        lnk;
        logic        unu;
        logic        rsv;
        logic        tk;
        logic [31:0] ofs;
        lnk = op >= `CBU_OP_L_LEZ && op <= `CBU_OP_L_NEZ;
        unu = (op == `CBU_OP_C2_EQZ || op == `CBU_OP_C2_NEZ) && !cop2_enable_i;
        rsv = op == `CBU_OP_NONE || op > `CBU_OP_LAST;
        tk = cond_of(op, a, b, flags[sel]) && !unu && !rsv;
        if (op <= `CBU_OP_L_NEZ) ofs = {{15{off[15]}}, off[15:0], 1'b0};
        else if (op >= `CBU_OP_Z_EQZ) ofs = {{9{off[20]}}, off, 2'b0};
        else ofs = {{14{off[15]}}, off[15:0], 2'b0};
        req_i = '{1'b1, op, pc, a, b, off, sel};
        @(posedge clock_i);
        #1;
        check({26'h0, res_o.valid, res_o.taken, res_o.squash_next, res_o.link_we,
               res_o.exc_cop_unusable, res_o.exc_reserved}, {26'h0, 1'b1, tk, tk, lnk, unu, rsv}, "flags");
        check(res_o.target, tk ? pc + 32'h4 + ofs : pc + 32'h4, "target");
        if (lnk) check(res_o.link_data, pc + 32'h4, "link");
        if (lnk) check({27'h0, res_o.link_reg}, {27'h0, 5'h1F}, "link register");
        check({27'h0, cop2_sel_o}, {27'h0, sel}, "selector");
        pc = pc + 32'h4;
    endtask : issue
    task automatic t_cop2(); // every selector in both polarities, then coprocessor off
        for (int s = 0; s < 64; s++) issue(s[5] ? `CBU_OP_C2_NEZ : `CBU_OP_C2_EQZ, 32'h0, 32'h0, 21'h0_8003, s[4:0]);
        cop2_enable_i = 1'b0;
        issue(`CBU_OP_C2_EQZ, 32'h0, 32'h0, 21'h3, 5'h01);
        issue(`CBU_OP_C2_NEZ, 32'h0, 32'h0, 21'h3, 5'h00);
        cop2_enable_i = 1'b1;
    endtask : t_cop2
    task automatic t_zero(); // link and zero compares just below, at and above zero
        logic [31:0] v;
        for (int op = 3; op <= 20; op++) begin
            for (int i = 0; i < 3; i++) begin
                v = i == 0 ? 32'hFFFF_FFFB : (i == 1 ? 32'h0 : 32'h7);
                if (op < 9 || op > 14) issue(op[4:0], op >= 19 ? v : ~v, op >= 19 ? ~v : v, 21'h1F_8002, 5'h0);
            end
        end
    endtask : t_zero
    task automatic t_regs(); // register compares at the sign boundary, both orders
        logic [31:0] pa [4] = '{32'h5, 32'hFFFF_FFFF, 32'h8000_0000, 32'h1};
        logic [31:0] pb [4] = '{32'h5, 32'h1, 32'h7FFF_FFFF, 32'h2};
        for (int op = 9; op <= 14; op++) begin
            for (int i = 0; i < 4; i++) begin
                issue(op[4:0], pa[i], pb[i], 21'h7FFF, 5'h0);
                issue(op[4:0], pb[i], pa[i], 21'h7FFF, 5'h0);
            end
        end
    endtask : t_regs
    task automatic t_reserved(); // unknown codes never branch
        issue(`CBU_OP_NONE, 32'h0, 32'h0, 21'h4, 5'h0);
        issue(5'h15, 32'h0, 32'h0, 21'h4, 5'h0);
    endtask : t_reserved
    task automatic test_done();
        if (fails == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done
    // hang guard: the whole run needs about 170 cycles
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            test_done();
        end
    end
    initial begin
        repeat (16) @(posedge clock_i);
        #1;
        sys_rst_i = 1'b0;
        @(posedge clock_i);
        #1;
        t_cop2();
        t_zero();
        t_regs();
        t_reserved();
        req_i.valid = 1'b0;
        @(posedge clock_i);
        #1;
        check({31'h0, res_o.valid}, 32'h0, "idle");
        test_done();
    end
endmodule : cbu_branch_unit_tb

// file: testbench/cbu_cop2_model.sv
// coprocessor 2 condition source: 32 single-bit flags picked by the selector
// assumes the selector comes straight from the request and is answered at once
`timescale 1ns/10ps
module cbu_cop2_model (
    input  wire logic [4:0]  sel_i,
    input  wire logic [31:0] flags_i,
    output logic             cond_o
);
    // every selector bit used, one flag each; combinational, so no stale value
    assign cond_o = flags_i[sel_i];
endmodule : cbu_cop2_model
